//--- bench/tb_top.sv
// self-checking bench for the timer top, driven over apb and the pin inputs
// assumes the package and design files are compiled before this one
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst, timerTick;     // clock, reset, prescaler enable
    logic        psel, penable, pwrite;   // apb request
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;   // rdVal: data taken at completion
    logic        pready, pslverr, errSeen;
    logic        portOutA, dirA, pinInA;  // port side of pin a
    logic        pinOutA, pinOeA, pinSyncA, wavA;
    logic        pinOutB, wavB, ovf, cfA, cfB;  // channel b and flag ports
    int          err_count, n_checks;
    tmr_timer8 dut (
        .clk(clk), .rst(rst), .timerTick(timerTick), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portOutA(portOutA), .portOutB(1'b0),
        .outputPinDirectionBitA(dirA), .outputPinDirectionBitB(1'b0), .pinInA(pinInA),
        .pinInB(1'b0), .pinOutA(pinOutA), .pinOutB(pinOutB), .pinOeA(pinOeA), .pinOeB(),
        .pinSyncA(pinSyncA), .pinSyncB(), .waveformOutputA(wavA), .waveformOutputB(wavB),
        .overflowFlag(ovf), .compareFlagA(cfA), .compareFlagB(cfB));
    // free running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one apb transfer; the leading edge keeps back-to-back calls from double driving
    task automatic apb(input logic isWr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= isWr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdVal = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rdVal, exp);
    endtask
    // exactly n timer ticks, started at the edge the caller stands on
    task automatic ticks(input int n);
        timerTick <= 1'b1;
        repeat (n) @(posedge clk);
        timerTick <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs far fewer cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin
        {rst, timerTick, psel, penable, pwrite} = 5'b10000;
        {paddr, pwdata} = '0;
        {portOutA, dirA, pinInA} = 3'b001;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdc(tmr_pkg::OFF_STATE, 32'h0, "state after reset");
        rdc(12'h01C, 32'h0, "unmapped read");
        check("unmapped error", errSeen, 1'b1);
        check("pin sync", pinSyncA, 1'b1);
        $display("test reset done");
        // normal mode wrap and overflow
        wr(tmr_pkg::OFF_COUNT, 32'hFE);
        ticks(2);
        rdc(tmr_pkg::OFF_COUNT, 32'h00, "normal wrap");
        rdc(tmr_pkg::OFF_FLAGS, 32'h01, "normal overflow");
        check("overflow port", ovf, 1'b1);
        wr(tmr_pkg::OFF_FLAGS, 32'h01);
        rdc(tmr_pkg::OFF_FLAGS, 32'h00, "overflow cleared");
        $display("test normal done");
        // ctc with toggle; load equal to compare masks that match
        wr(tmr_pkg::OFF_CTRL, 32'h42);
        wr(tmr_pkg::OFF_CMPA, 32'h03);
        wr(tmr_pkg::OFF_COUNT, 32'h03);
        ticks(1);
        rdc(tmr_pkg::OFF_COUNT, 32'h04, "count past blocked match");
        ticks(251);
        rdc(tmr_pkg::OFF_FLAGS, 32'h00, "top below count missed");
        ticks(5);
        rdc(tmr_pkg::OFF_COUNT, 32'h00, "ctc clear at top");
        rdc(tmr_pkg::OFF_FLAGS, 32'h07, "ctc flags");
        check("compare flag a port", cfA, 1'b1);
        check("compare flag b port", cfB, 1'b1);
        rdc(tmr_pkg::OFF_STATE, 32'h01, "ctc toggle");
        ticks(4);
        rdc(tmr_pkg::OFF_STATE, 32'h00, "ctc toggle back");
        check("wave output a", wavA, 1'b0);
        $display("test ctc done");
        // force strobes on both channels and port override
        wr(tmr_pkg::OFF_FLAGS, 32'h07);
        wr(tmr_pkg::OFF_CTRL, 32'h50);
        wr(tmr_pkg::OFF_FORCE, 32'h03);
        dirA <= 1'b1;
        rdc(tmr_pkg::OFF_STATE, 32'h03, "forced toggle");
        rdc(tmr_pkg::OFF_FLAGS, 32'h00, "force sets no flag");
        rdc(tmr_pkg::OFF_COUNT, 32'h00, "force keeps count");
        check("override pin", pinOutA, 1'b1);
        check("override pin b", pinOutB, 1'b1);
        check("pin enable", pinOeA, 1'b1);
        wr(tmr_pkg::OFF_CTRL, 32'h00);
        wr(tmr_pkg::OFF_FORCE, 32'h03);
        rdc(tmr_pkg::OFF_STATE, 32'h03, "mode zero keeps state");
        check("port pin", pinOutA, 1'b0);
        wr(tmr_pkg::OFF_CTRL, 32'h10);
        wr(tmr_pkg::OFF_FORCE, 32'h02);
        rdc(tmr_pkg::OFF_STATE, 32'h01, "forced toggle b back");
        check("wave output b", wavB, 1'b0);
        $display("test force done");
        // fast pwm, top ff non-inverting then inverting, then toggle with top ff and top a
        wr(tmr_pkg::OFF_CTRL, 32'h83);
        wr(tmr_pkg::OFF_CMPA, 32'h10);
        wr(tmr_pkg::OFF_COUNT, 32'hFD);
        ticks(3);
        rdc(tmr_pkg::OFF_COUNT, 32'h00, "pwm clear after top");
        rdc(tmr_pkg::OFF_FLAGS, 32'h01, "pwm overflow at top");
        ticks(17);
        rdc(tmr_pkg::OFF_STATE, 32'h00, "clear on match");
        wr(tmr_pkg::OFF_CTRL, 32'hC3);
        ticks(239);
        rdc(tmr_pkg::OFF_STATE, 32'h00, "clear at bottom");
        ticks(17);
        rdc(tmr_pkg::OFF_STATE, 32'h01, "set on match");
        ticks(239);
        rdc(tmr_pkg::OFF_STATE, 32'h00, "cleared at bottom");
        ticks(17);
        rdc(tmr_pkg::OFF_STATE, 32'h01, "set on match again");
        wr(tmr_pkg::OFF_CTRL, 32'h43);
        ticks(256);
        rdc(tmr_pkg::OFF_STATE, 32'h01, "no toggle without high bit");
        wr(tmr_pkg::OFF_CTRL, 32'h47);
        ticks(256);
        rdc(tmr_pkg::OFF_COUNT, 32'h00, "top from compare a");
        rdc(tmr_pkg::OFF_STATE, 32'h00, "toggle at top");
        $display("test fast pwm done");
        complete_run();
    end
endmodule // tb_top

//--- bench/tmr_timer8_sva.sv
// checker for the timer top: flag, output and pin relations at its ports
// assumes it is bound to tmr_timer8 and sees only that module's ports
`timescale 1ns/1ps
module tmr_timer8_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        timerTick,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        outputPinDirectionBitA,
    input wire logic        pinOeA,
    input wire logic        waveformOutputA,
    input wire logic        overflowFlag,
    input wire logic        compareFlagA,
    input wire logic        compareFlagB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire wrAcc   = psel && penable && pwrite;               // write completes now
    wire wrFlags = wrAcc && paddr == tmr_pkg::OFF_FLAGS;    // flag clear access
    wire wrCount = wrAcc && paddr == tmr_pkg::OFF_COUNT;    // counter load access
    wire wrForce = wrAcc && paddr == tmr_pkg::OFF_FORCE;    // force strobe access
    // pin driver enable follows the direction bit only
    property p_oe; pinOeA == outputPinDirectionBitA; endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from direction");
    // first edge after release sees cleared state a and overflow flag
    property p_rst; $fell(rst) |-> !waveformOutputA && !overflowFlag; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    // without a tick and without a write state a, overflow and compare a flag may not move
    property p_hold; !timerTick && !wrAcc |=> $stable(waveformOutputA)
        && $stable(overflowFlag) && $stable(compareFlagA); endproperty
    a_hold: assert property (p_hold) else $error("change without timer tick");
    property p_ovf; $rose(overflowFlag) |-> $past(timerTick); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow set off tick");
    property p_cmpa; $rose(compareFlagA) |-> $past(timerTick); endproperty
    a_cmpa: assert property (p_cmpa) else $error("compare flag set off tick");
    // compare flag a only falls through a write of one to its bit
    property p_clr; $fell(compareFlagA) |-> $past(wrFlags && pwdata[tmr_pkg::FLAG_CMPA]);
    endproperty
    a_clr: assert property (p_clr) else $error("compare flag lost without write");
    property p_frc; wrForce && !timerTick |=> !$rose(compareFlagA) && !$rose(compareFlagB);
    endproperty
    a_frc: assert property (p_frc) else $error("force set a compare flag");
    // a counter load masks the match of the following tick
    property p_blk; wrCount && !timerTick ##1 timerTick |=> !$rose(compareFlagA); endproperty
    a_blk: assert property (p_blk) else $error("match not blocked after load");
endmodule // tmr_timer8_sva
bind tmr_timer8 tmr_timer8_sva u_sva (.clk(clk), .rst(rst), .timerTick(timerTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .outputPinDirectionBitA(outputPinDirectionBitA), .pinOeA(pinOeA),
    .waveformOutputA(waveformOutputA), .overflowFlag(overflowFlag),
    .compareFlagA(compareFlagA), .compareFlagB(compareFlagB));

//--- logic/tmr_cmp_ch.sv
// one compare channel: buffered compare value and output state register
// assumes enables and strobes come from logic on the same clock
`timescale 1ns/1ps
module tmr_cmp_ch #(
    parameter bit TOGGLE_OK = 1'b1  // channel a may toggle in fast pwm
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,        // timer clock enable
    input  wire logic       pwmMode,     // fast pwm active
    input  wire logic       highBit,     // waveform_mode_high_bit
    input  wire logic [1:0] modeBits,    // compare_output_mode_bits
    input  wire logic [7:0] counterValue,
    input  wire logic       atTop,       // counter equals top
    input  wire logic       atBottom,    // counter turns to bottom this tick
    input  wire logic       blockMatch,  // counter write blocks this tick
    input  wire logic       writeCmp,    // software writes compare
    input  wire logic [7:0] writeData,
    input  wire logic       forceStrobe, // force_compare_strobe
    output logic      [7:0] compareValue,
    output logic      [7:0] compareBuffer,
    output logic            matchNow,    // combinational match this tick
    output logic            outState     // compare_output_state
);
    logic [7:0] active;     // value the comparator uses
    logic       isMatch;    // comparator result
    logic       doMatch;    // match acting on output
    logic       topIgnore;  // pwm match ignored at top with high mode bit
    logic       toggleOk;   // toggle allowed in current mode
    logic       next_out;   // next output state

    assign compareValue = active;
    assign isMatch      = (counterValue == active);
    assign matchNow     = tick && isMatch && !blockMatch;
    assign topIgnore    = pwmMode && modeBits[1] && atTop && isMatch;
    assign doMatch      = matchNow && !topIgnore;
    assign toggleOk     = !pwmMode || (TOGGLE_OK && highBit);

    // output action; zero mode never changes state
    always_comb begin
        next_out = outState;
        if (doMatch || (forceStrobe && !pwmMode)) begin
            case (modeBits)
                2'b01: next_out = toggleOk ? !outState : outState;
                2'b10: next_out = 1'b0;
                2'b11: next_out = 1'b1;
                default: next_out = outState;
            endcase
        end
        // pwm bottom action, wins after match at the wrap
        if (pwmMode && tick && atBottom) begin
            if (modeBits == 2'b10) begin
                next_out = 1'b1;
            end else if (modeBits == 2'b11) begin
                next_out = 1'b0;
            end
        end
    end

    // state register, reset clears it, otherwise takes next_out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outState <= 1'b0;
        end else begin
            outState <= next_out;
        end
    end

    // software sees the buffer; pwm loads active at top
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compareBuffer <= tmr_pkg::RST_BYTE;
            active        <= tmr_pkg::RST_BYTE;
        end else begin
            if (writeCmp) begin
                compareBuffer <= writeData;
            end
            if (!pwmMode && writeCmp) begin
                active <= writeData;
            end else if (pwmMode && tick && atTop) begin
                active <= compareBuffer;
            end else if (!pwmMode) begin
                active <= compareBuffer;
            end
        end
    end
endmodule // tmr_cmp_ch

//--- logic/tmr_pkg.sv
// constants for the 8-bit timer with compare outputs and its apb register file
// assumes an apb master on the same clock and a prescaler giving a timer enable
// Function
// - reset clears both compare output states
// - nonzero output mode overrides general port pin
// - override ignores the waveform mode
// - output mode zero leaves state unchanged
// - mode change acts at next match; force immediate; code ignores force in fast pwm modes 3 and 7
// - waveform bits set count; output bits action
// - mode 0 counts up, wraps ff to 00
// - mode 0 overflow set when counter becomes zero
// - mode 0 counter writable any time
// - mode 2 clears counter on compare a
// - mode 2 compare a unbuffered, may miss match
// - mode 2 sets compare flag a at top
// - mode 2 output mode 1 toggles output a
// - mode 2 overflow set on max to zero
// - modes 3 and 7 single slope, top ff or a
// - fast pwm modes 2 and 3 match/bottom actions
// - fast pwm clears counter cycle after top
// - fast pwm overflow set at top
// - fast pwm toggle a only with high bit
// - fast pwm extreme compare values behave specially
// - fast pwm buffers compare even when toggling
// - pwm buffers compare; other modes write direct
// - force updates output, no flag, no clear; code ignores force in fast pwm modes 3 and 7
// - match sets flag next tick; write one clears
// - counter write blocks match next tick
package tmr_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_CTRL    = 12'h000; // output modes, waveform mode
    localparam logic [11:0] OFF_COUNT   = 12'h004; // counter value
    localparam logic [11:0] OFF_CMPA    = 12'h008; // compare value a
    localparam logic [11:0] OFF_CMPB    = 12'h00C; // compare value b
    localparam logic [11:0] OFF_FLAGS   = 12'h010; // flags, write one clears
    localparam logic [11:0] OFF_FORCE   = 12'h014; // force strobes, write only
    localparam logic [11:0] OFF_STATE   = 12'h018; // output states, read only
    // control field positions
    localparam int CTRL_WGM_LSB = 0;  // waveform_mode_select, 3 bits
    localparam int CTRL_COMB_LSB = 4; // output b mode, 2 bits
    localparam int CTRL_COMA_LSB = 6; // output_a_mode_bits, 2 bits
    // flag positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    // force positions
    localparam int FORCE_A = 0;
    localparam int FORCE_B = 1;
    // reset value and count limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] MAX_COUNT = 8'hFF;
    localparam logic [7:0] BOTTOM = 8'h00;
    // waveform modes
    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'b000,
        WGM_PC_FF    = 3'b001,
        WGM_CTC      = 3'b010,
        WGM_FAST_FF  = 3'b011,
        WGM_RSV4     = 3'b100,
        WGM_PC_A     = 3'b101,
        WGM_RSV6     = 3'b110,
        WGM_FAST_A   = 3'b111
    } tmr_wgm_t;
    // compare output actions
    typedef enum logic [1:0] {
        COM_OFF    = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR  = 2'b10,
        COM_SET    = 2'b11
    } tmr_com_t;
endpackage

//--- logic/tmr_sync.sv
// two-stage synchroniser for an asynchronous level input
// assumes the level is slow against clk
`timescale 1ns/1ps
module tmr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1; // read only by the second stage

    // plain double flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // tmr_sync

//--- logic/tmr_timer8.sv
// top of the 8-bit timer: counter, flags, apb registers and pin override
// assumes a timer enable pulse from a prescaler on clk and apb on clk
`timescale 1ns/1ps
module tmr_timer8 (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        timerTick,     // prescaler enable, same clock
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // port pins
    input  wire logic        portOutA,       // general port value, pin a
    input  wire logic        portOutB,
    input  wire logic        outputPinDirectionBitA, // output_pin_direction_bit
    input  wire logic        outputPinDirectionBitB,
    input  wire logic        pinInA,          // pin level in, asynchronous
    input  wire logic        pinInB,
    output logic             pinOutA,
    output logic             pinOutB,
    output logic             pinOeA,
    output logic             pinOeB,
    output logic             pinSyncA,        // synchronised pin level
    output logic             pinSyncB,
    output logic             waveformOutputA, // compare state a
    output logic             waveformOutputB,
    output logic             overflowFlag,
    output logic             compareFlagA,
    output logic             compareFlagB
);
    logic [7:0] ctrl;          // output modes and waveform mode
    logic [7:0] counterValue;  // counter
    logic       blockPend;     // counter written, block next tick match
    logic [2:0] waveformModeSelect;
    logic [1:0] outputAModeBits;
    logic [1:0] outputBModeBits;
    logic       pwmMode;       // fast pwm, modes 3 and 7
    logic [7:0] topValue;
    logic       atTop;
    logic       atBottomNext;  // counter becomes zero this tick
    logic       clearOnTop;    // ctc or fast pwm wrap
    logic [7:0] next_counter;
    logic       acc;           // apb access phase
    logic       wr;
    logic       wrCtrl, wrCount, wrCmpA, wrCmpB, wrFlags, wrForce;
    logic       hitAddr;
    logic [7:0] cmpValA, cmpBufA, cmpBufB;
    logic       matchA, matchB;
    logic       setOvf;
    logic       setCmpA;
    logic       setCmpB;
    logic       forceA, forceB;

    // field decode
    assign waveformModeSelect = ctrl[tmr_pkg::CTRL_WGM_LSB +: 3];
    assign outputAModeBits    = ctrl[tmr_pkg::CTRL_COMA_LSB +: 2];
    assign outputBModeBits    = ctrl[tmr_pkg::CTRL_COMB_LSB +: 2];
    assign pwmMode = (waveformModeSelect == tmr_pkg::WGM_FAST_FF) ||
                     (waveformModeSelect == tmr_pkg::WGM_FAST_A);

    // top chosen by waveform bits: compare a value in modes 2 and 7, ff otherwise
    assign topValue = (waveformModeSelect == tmr_pkg::WGM_FAST_A ||
                       waveformModeSelect == tmr_pkg::WGM_CTC) ?
                      cmpValA : tmr_pkg::MAX_COUNT;
    assign atTop      = (counterValue == topValue);
    assign clearOnTop = (waveformModeSelect == tmr_pkg::WGM_CTC) || pwmMode;

    // apb decode; zero wait states
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign pready  = 1'b1;
    assign hitAddr = (paddr == tmr_pkg::OFF_CTRL)  || (paddr == tmr_pkg::OFF_COUNT) ||
                     (paddr == tmr_pkg::OFF_CMPA)  || (paddr == tmr_pkg::OFF_CMPB)  ||
                     (paddr == tmr_pkg::OFF_FLAGS) || (paddr == tmr_pkg::OFF_FORCE) ||
                     (paddr == tmr_pkg::OFF_STATE);
    assign pslverr = acc && !hitAddr;
    assign wrCtrl  = wr && (paddr == tmr_pkg::OFF_CTRL);
    assign wrCount = wr && (paddr == tmr_pkg::OFF_COUNT);
    assign wrCmpA  = wr && (paddr == tmr_pkg::OFF_CMPA);
    assign wrCmpB  = wr && (paddr == tmr_pkg::OFF_CMPB);
    assign wrFlags = wr && (paddr == tmr_pkg::OFF_FLAGS);
    assign wrForce = wr && (paddr == tmr_pkg::OFF_FORCE);
    assign forceA  = wrForce && pwdata[tmr_pkg::FORCE_A];
    assign forceB  = wrForce && pwdata[tmr_pkg::FORCE_B];

    // counter step; software write wins over all counting
    always_comb begin
        next_counter = counterValue;
        atBottomNext = 1'b0;
        if (wrCount) begin
            next_counter = pwdata[7:0];
        end else if (timerTick) begin
            // a blocked ctc match must not clear the counter either
            if (clearOnTop && atTop &&
                !(blockPend && waveformModeSelect == tmr_pkg::WGM_CTC)) begin
                next_counter = tmr_pkg::BOTTOM;
                atBottomNext = 1'b1;
            end else begin
                next_counter = counterValue + 8'h01;
                atBottomNext = (counterValue == tmr_pkg::MAX_COUNT);
            end
        end
    end

    // counter register and match blocking after a write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counterValue <= tmr_pkg::RST_BYTE;
            blockPend    <= 1'b0;
        end else begin
            counterValue <= next_counter;
            if (wrCount) begin
                blockPend <= 1'b1;
            end else if (timerTick) begin
                blockPend <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= tmr_pkg::RST_BYTE;
        end else if (wrCtrl) begin
            ctrl <= pwdata[7:0];
        end
    end

    // flag sources; overflow at top in pwm, at wrap otherwise
    assign setOvf  = timerTick && (pwmMode ? atTop :
                     (atBottomNext && counterValue == tmr_pkg::MAX_COUNT));
    assign setCmpA = matchA;
    assign setCmpB = matchB;

    // flags: set wins over write-one clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflowFlag <= 1'b0;
            compareFlagA <= 1'b0;
            compareFlagB <= 1'b0;
        end else begin
            overflowFlag <= setOvf ||
                (overflowFlag && !(wrFlags && pwdata[tmr_pkg::FLAG_OVF]));
            compareFlagA <= setCmpA ||
                (compareFlagA && !(wrFlags && pwdata[tmr_pkg::FLAG_CMPA]));
            compareFlagB <= setCmpB ||
                (compareFlagB && !(wrFlags && pwdata[tmr_pkg::FLAG_CMPB]));
        end
    end

    // channel a may toggle in fast pwm
    tmr_cmp_ch #(.TOGGLE_OK(1'b1)) u_chA (
        .clk          (clk),
        .rst          (rst),
        .tick         (timerTick),
        .pwmMode      (pwmMode),
        .highBit      (waveformModeSelect[2]),
        .modeBits     (outputAModeBits),
        .counterValue (counterValue),
        .atTop        (atTop),
        .atBottom     (atBottomNext && !wrCount),
        .blockMatch   (blockPend),
        .writeCmp     (wrCmpA),
        .writeData    (pwdata[7:0]),
        .forceStrobe  (forceA),
        .compareValue (cmpValA),
        .compareBuffer(cmpBufA),
        .matchNow     (matchA),
        .outState     (waveformOutputA)
    );

    // channel b has no toggle in fast pwm
    tmr_cmp_ch #(.TOGGLE_OK(1'b0)) u_chB (
        .clk          (clk),
        .rst          (rst),
        .tick         (timerTick),
        .pwmMode      (pwmMode),
        .highBit      (waveformModeSelect[2]),
        .modeBits     (outputBModeBits),
        .counterValue (counterValue),
        .atTop        (atTop),
        .atBottom     (atBottomNext && !wrCount),
        .blockMatch   (blockPend),
        .writeCmp     (wrCmpB),
        .writeData    (pwdata[7:0]),
        .forceStrobe  (forceB),
        .compareValue (),
        .compareBuffer(cmpBufB),
        .matchNow     (matchB),
        .outState     (waveformOutputB)
    );

    // pin override depends on output mode bits only
    assign pinOutA = (outputAModeBits != 2'b00) ? waveformOutputA : portOutA;
    assign pinOutB = (outputBModeBits != 2'b00) ? waveformOutputB : portOutB;
    assign pinOeA  = outputPinDirectionBitA;
    assign pinOeB  = outputPinDirectionBitB;

    // pin levels back in through synchronisers
    tmr_sync u_syncA (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (pinInA),
        .syncOut (pinSyncA)
    );
    tmr_sync u_syncB (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (pinInB),
        .syncOut (pinSyncB)
    );

    // registered read data; unmapped reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                tmr_pkg::OFF_CTRL:  prdata <= {24'h000000, ctrl};
                tmr_pkg::OFF_COUNT: prdata <= {24'h000000, counterValue};
                tmr_pkg::OFF_CMPA:  prdata <= {24'h000000, cmpBufA};
                tmr_pkg::OFF_CMPB:  prdata <= {24'h000000, cmpBufB};
                tmr_pkg::OFF_FLAGS: prdata <= {29'h00000000, compareFlagB,
                                               compareFlagA, overflowFlag};
                tmr_pkg::OFF_STATE: prdata <= {30'h00000000, waveformOutputB,
                                               waveformOutputA};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // tmr_timer8
